// ==== hw/brb_pkg.sv ====
// package: register map, field positions and reset values of the bias register bank
package brb_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [4:0] ADDR_SYSTEM_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_GROUP_A_SENSE_REFERENCE = 5'h01;
  localparam logic [4:0] ADDR_GROUP_A_DRIVER_GATE_SETTING = 5'h02;
  localparam logic [4:0] ADDR_GROUP_A_FINAL_GATE_SETTING = 5'h03;
  localparam logic [4:0] ADDR_GROUP_B_SENSE_REFERENCE = 5'h04;
  localparam logic [4:0] ADDR_GROUP_B_DRIVER_GATE_SETTING = 5'h05;
  localparam logic [4:0] ADDR_GROUP_B_FINAL_GATE_SETTING = 5'h06;
  localparam logic [4:0] ADDR_TEMPERATURE_READING = 5'h0F;
  localparam logic [4:0] ADDR_OVERRIDE_UNLOCK_KEY = 5'h11;
  localparam int BIAS_COUNT = 6;
  localparam int SOFT_RESET_BIT = 6;
  localparam int RELOAD_BIT = 5;
  localparam int SENSE_W = 6;
  localparam logic [7:0] SENSE_MASK = 8'h3F;
  localparam logic [7:0] UNLOCK_CODE = 8'hE3;
  localparam logic [7:0] BIAS_RESET_VALUE = 8'h00;
  // chip revision: value is arbitrary
  localparam logic [3:0] REVISION_DEFAULT = 4'h5;
endpackage

// ==== hw/brb_bias_bank.sv ====
// bias register bank with one-time memory shadow and override unlock
module brb_bias_bank
  import brb_pkg::*;
#(
  parameter logic [3:0] REVISION = REVISION_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWriteData,
  output logic [DATA_W-1:0] regReadData,
  input wire logic [DATA_W*BIAS_COUNT-1:0] fuseImage,
  input wire logic [DATA_W-1:0] temperatureValue,
  output logic [DATA_W*BIAS_COUNT-1:0] biasSettings,
  output logic engineeringOverrideMode
);

  function automatic logic [7:0] fieldMask(input int idx);
    fieldMask = (idx == 0 || idx == 3) ? SENSE_MASK : 8'hFF;
  endfunction

  logic [7:0] bias_q [BIAS_COUNT];
  logic [7:0] bias_d [BIAS_COUNT];
  logic softReset_q;
  logic reload_q;
  logic loadPending_q;
  logic override_q;
  logic override_d;
  logic [7:0] readData_q;
  logic [7:0] readData_d;

  wire sysWrite = regWrite && (regAddr == ADDR_SYSTEM_CONTROL);
  wire keyWrite = regWrite && (regAddr == ADDR_OVERRIDE_UNLOCK_KEY);
  // soft reset bit written to one
  wire softResetHit = sysWrite && regWriteData[SOFT_RESET_BIT];
  // reload bit written to one with the soft reset bit written to zero
  wire reloadHit = sysWrite && regWriteData[RELOAD_BIT] && !regWriteData[SOFT_RESET_BIT];
  wire fuseLoad = loadPending_q || softResetHit || reloadHit;
  wire biasAddrHit = (regAddr >= ADDR_GROUP_A_SENSE_REFERENCE) && (regAddr <= ADDR_GROUP_B_FINAL_GATE_SETTING);
  wire [2:0] biasIdx = 3'(regAddr - ADDR_GROUP_A_SENSE_REFERENCE);

  always_comb begin
    for (int i = 0; i < BIAS_COUNT; i++) begin
      bias_d[i] = bias_q[i];
      if (fuseLoad) begin
        bias_d[i] = fuseImage[i*DATA_W +: DATA_W] & fieldMask(i);
      end else if (regWrite && biasAddrHit && override_q && (int'(biasIdx) == i)) begin
        bias_d[i] = regWriteData & fieldMask(i);
      end
    end
  end

  always_comb begin
    override_d = override_q;
    if (softResetHit) begin
      override_d = 1'b0;
    end else if (keyWrite && regWriteData == UNLOCK_CODE) begin
      override_d = 1'b1;
    end else if (keyWrite) begin
      override_d = 1'b0;
    end
  end

  always_comb begin
    readData_d = 8'h00;
    if (regAddr == ADDR_SYSTEM_CONTROL) begin
      readData_d = {1'b0, softReset_q, reload_q, 1'b0, REVISION};
    end else if (biasAddrHit) begin
      readData_d = bias_q[biasIdx];
    end else if (regAddr == ADDR_TEMPERATURE_READING) begin
      readData_d = temperatureValue;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loadPending_q <= 1'b1;
    end else begin
      loadPending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < BIAS_COUNT; i++) begin
        bias_q[i] <= BIAS_RESET_VALUE;
      end
      override_q <= 1'b0;
    end else begin
      bias_q <= bias_d;
      override_q <= override_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      softReset_q <= 1'b0;
      reload_q <= 1'b0;
    end else if (sysWrite) begin
      softReset_q <= regWriteData[SOFT_RESET_BIT];
      reload_q <= regWriteData[RELOAD_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readData_q <= 8'h00;
    end else if (regRead) begin
      readData_q <= readData_d;
    end
  end

  always_comb begin
    for (int i = 0; i < BIAS_COUNT; i++) begin
      biasSettings[i*DATA_W +: DATA_W] = bias_q[i];
    end
  end
  assign regReadData = readData_q;
  assign engineeringOverrideMode = override_q;

  a_reset_load: assert property (@(posedge clk) disable iff (!reset_n)
    (reset_n && loadPending_q) |=> (bias_q[1] == $past(fuseImage[15:8])
      && bias_q[0] == ($past(fuseImage[7:0]) & SENSE_MASK)
      && bias_q[3] == ($past(fuseImage[31:24]) & SENSE_MASK)))
    else $error("bias not loaded from fuses after reset");
  a_locked_write: assert property (@(posedge clk) disable iff (!reset_n)
    (regWrite && biasAddrHit && !override_q && !fuseLoad && regAddr == 5'h02) |=> $stable(bias_q[1]))
    else $error("bias changed while locked");
  a_unlocked_write: assert property (@(posedge clk) disable iff (!reset_n)
    (regWrite && regAddr == 5'h03 && override_q && !fuseLoad) |=> bias_q[2] == $past(regWriteData))
    else $error("unlocked write not taken");
  a_unlock_code: assert property (@(posedge clk) disable iff (!reset_n)
    (keyWrite && regWriteData == 8'hE3 && !softResetHit) |=> engineeringOverrideMode)
    else $error("passcode did not unlock");
  a_wrong_code: assert property (@(posedge clk) disable iff (!reset_n)
    (keyWrite && regWriteData != 8'hE3) |=> !engineeringOverrideMode)
    else $error("wrong passcode left mode on");
  a_soft_reset: assert property (@(posedge clk) disable iff (!reset_n)
    softResetHit |=> (!engineeringOverrideMode && bias_q[5] == $past(fuseImage[47:40])))
    else $error("soft reset did not restore defaults");
  a_reload_copy: assert property (@(posedge clk) disable iff (!reset_n)
    reloadHit |=> bias_q[4] == $past(fuseImage[39:32]))
    else $error("reload did not copy fuses");
  a_sense_width: assert property (@(posedge clk) disable iff (!reset_n)
    bias_q[0][7:6] == 2'b00 && bias_q[3][7:6] == 2'b00)
    else $error("sense reference upper bits set");
  a_temp_read: assert property (@(posedge clk) disable iff (!reset_n)
    (regRead && regAddr == 5'h0F) |=> regReadData == $past(temperatureValue))
    else $error("temperature read wrong");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (regRead && ((regAddr >= 5'h07 && regAddr <= 5'h0E) || regAddr == 5'h10 || regAddr == 5'h11))
    |=> regReadData == 8'h00)
    else $error("reserved or key read not zero");
  a_revision_read: assert property (@(posedge clk) disable iff (!reset_n)
    (regRead && regAddr == 5'h00) |=> regReadData[3:0] == REVISION && regReadData[7] == 1'b0)
    else $error("revision field wrong");
  a_locked_any: assert property (@(posedge clk) disable iff (!reset_n)
    (regWrite && biasAddrHit && !override_q && !fuseLoad) |=> $stable(biasSettings))
    else $error("locked bias write changed a setting");
  a_mode_stays_off: assert property (@(posedge clk) disable iff (!reset_n)
    (!override_q && !(keyWrite && regWriteData == UNLOCK_CODE)) |=> !engineeringOverrideMode)
    else $error("override mode came on without the key");
  a_mode_holds: assert property (@(posedge clk) disable iff (!reset_n)
    (override_q && !keyWrite && !softResetHit) |=> engineeringOverrideMode)
    else $error("override mode dropped without cause");
  a_read_holds: assert property (@(posedge clk) disable iff (!reset_n)
    !regRead |=> $stable(regReadData))
    else $error("read data changed without a read");
  a_control_read: assert property (@(posedge clk) disable iff (!reset_n)
    (regRead && regAddr == ADDR_SYSTEM_CONTROL) |=> regReadData[4] == 1'b0)
    else $error("unused control bit read as one");
  a_bias_readback: assert property (@(posedge clk) disable iff (!reset_n)
    (regRead && regAddr == ADDR_GROUP_B_FINAL_GATE_SETTING) |=> regReadData == $past(biasSettings[47:40]))
    else $error("bias readback wrong");
  a_temp_write: assert property (@(posedge clk) disable iff (!reset_n)
    (regWrite && regAddr == ADDR_TEMPERATURE_READING && !loadPending_q)
    |=> $stable(biasSettings) && $stable(engineeringOverrideMode))
    else $error("temperature write changed state");
  a_reserved_write: assert property (@(posedge clk) disable iff (!reset_n)
    (regWrite && ((regAddr >= 5'h07 && regAddr <= 5'h0E) || regAddr == 5'h10) && !loadPending_q)
    |=> $stable(biasSettings) && $stable(engineeringOverrideMode))
    else $error("reserved write changed state");
  a_reload_mode: assert property (@(posedge clk) disable iff (!reset_n)
    reloadHit |=> engineeringOverrideMode == $past(engineeringOverrideMode))
    else $error("reload changed override mode");
  a_sense_write: assert property (@(posedge clk) disable iff (!reset_n)
    (regWrite && regAddr == ADDR_GROUP_B_SENSE_REFERENCE && override_q && !fuseLoad)
    |=> bias_q[3] == ($past(regWriteData) & SENSE_MASK))
    else $error("sense write not masked to six bits");

  c_unlock: cover property (@(posedge clk) disable iff (!reset_n) keyWrite && regWriteData == 8'hE3);
  c_bias_write: cover property (@(posedge clk) disable iff (!reset_n) regWrite && biasAddrHit && override_q);
  c_soft_reset: cover property (@(posedge clk) disable iff (!reset_n) softResetHit);
  c_reload: cover property (@(posedge clk) disable iff (!reset_n) reloadHit);
  c_locked_write: cover property (@(posedge clk) disable iff (!reset_n) regWrite && biasAddrHit && !override_q);
endmodule

// ==== test/brb_host_model.sv ====
// host model: one register access at a time on the strobe port
module brb_host_model
  import brb_pkg::*;
(
  input wire logic clk,
  output logic regWrite,
  output logic regRead,
  output logic [ADDR_W-1:0] regAddr,
  output logic [DATA_W-1:0] regWriteData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {regWrite, regRead, regAddr, regWriteData} = '0;
  // one-cycle strobe, then address and data stop showing the last value
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    {regWrite, regRead, regAddr, regWriteData} <= {w, !w, a, d};
    @(posedge clk);
    {regWrite, regRead, regAddr, regWriteData} <= {2'b00, ~a, ~d};
  endtask
endmodule

// ==== test/tb.sv ====
// bench: host model drives the bank, reads checked from a queue
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import brb_pkg::*;
  localparam logic [47:0] FM = {8'hFF, 8'hFF, SENSE_MASK, 8'hFF, 8'hFF, SENSE_MASK};
  logic clk = 1'b0, reset_n = 1'b0, we, re, mode, rdPend = 1'b0;
  logic [4:0] ad;
  logic [7:0] wd, rdata, temp, v;
  logic [47:0] fuse, bias, bExp;
  logic [31:0] rng = 32'h0000000A;
  logic [7:0] expQ[$];
  int errTotal = 0, cmpCount = 0, cycles = 0;
  brb_host_model brb_host_model_i(.clk(clk), .regWrite(we), .regRead(re), .regAddr(ad), .regWriteData(wd));
  brb_bias_bank brb_bias_bank_i(.clk(clk), .reset_n(reset_n), .regWrite(we), .regRead(re), .regAddr(ad),
    .regWriteData(wd), .regReadData(rdata), .fuseImage(fuse), .temperatureValue(temp), .biasSettings(bias),
    .engineeringOverrideMode(mode));
  function automatic logic [31:0] nx();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic check(input string n, input logic [48:0] s, input logic [48:0] e);
    cmpCount++;
    errTotal += int'(s !== e);
    if (s !== e) $display("MISMATCH %s expected %h seen %h", n, e, s);
  endtask
  task automatic chk(input logic [47:0] b, input logic m);
    repeat (2) @(negedge clk);
    check("bias and mode", {bias, mode}, {b, m});
  endtask
  task automatic io(input logic w, input logic [4:0] a, input logic [7:0] d);
    if (!w) expQ.push_back(d);
    brb_host_model_i.acc(w, a, d);
  endtask
  task automatic tally_and_finish();
    if (errTotal == 0 && cmpCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    if (rdPend) check("read data", 49'(rdata), 49'(expQ.pop_front()));
    rdPend <= re;
    cycles <= cycles + 1;
    if (cycles == 3000) check("timeout", 49'h0, 49'h1);
    if (cycles == 3000) tally_and_finish();
  end
  initial begin
    {fuse, temp} = 56'({nx(), nx()});
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(fuse & FM, 1'b0);
    io(1'b0, 5'h00, {4'h0, REVISION_DEFAULT});
    io(1'b1, 5'h02, 8'h5A);
    io(1'b1, 5'h11, 8'hE2);
    chk(fuse & FM, 1'b0);
    io(1'b0, 5'h11, 8'h00);
    io(1'b1, 5'h11, UNLOCK_CODE);
    for (int a = 1; a <= 16; a++) begin
      v = 8'(nx());
      if (a <= 6) bExp[8*a-8+:8] = v & ((a % 3 == 1) ? SENSE_MASK : 8'hFF);
      io(1'b1, 5'(a), v);
      io(1'b0, 5'(a), (a == 15) ? temp : (a <= 6) ? bExp[8*a-8+:8] : 8'h00);
    end
    chk(bExp, 1'b1);
    io(1'b1, 5'h00, 8'h20);
    chk(fuse & FM, 1'b1);
    io(1'b0, 5'h00, {4'h2, REVISION_DEFAULT});
    io(1'b1, 5'h03, ~fuse[23:16]);
    io(1'b1, 5'h00, 8'h40);
    chk(fuse & FM, 1'b0);
    io(1'b0, 5'h00, {4'h4, REVISION_DEFAULT});
    io(1'b1, 5'h03, ~fuse[23:16]);
    io(1'b1, 5'h00, 8'h00);
    chk(fuse & FM, 1'b0);
    @(posedge clk);
    fuse <= ~fuse;
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(fuse & FM, 1'b0);
    tally_and_finish();
  end
endmodule
